// ---- src/motion_power_control_params.svh ----
// constants for the motion / power control register bank
// assumes byte-wide registers on a plain strobe port, 50 MHz system clock
`ifndef MOTION_POWER_CONTROL_PARAMS_SVH
`define MOTION_POWER_CONTROL_PARAMS_SVH

// register offsets
`define MPC_OFS_MOTION_DETECT_CTRL 8'h69
`define MPC_OFS_FIFO_AND_PATH_CTRL 8'h6A
`define MPC_OFS_POWER_CLOCK_CTRL 8'h6B
`define MPC_OFS_AXIS_STANDBY_CTRL 8'h6C

// reset values
`define MPC_RST_MOTION_DETECT_CTRL 8'h00
`define MPC_RST_FIFO_AND_PATH_CTRL 8'h00
`define MPC_RST_POWER_CLOCK_CTRL 8'h01
`define MPC_RST_AXIS_STANDBY_CTRL 8'h00

// writable bit masks, reserved bits stay zero
`define MPC_MASK_MOTION_DETECT_CTRL 8'hC3
`define MPC_MASK_FIFO_AND_PATH_CTRL 8'h45
`define MPC_MASK_POWER_CLOCK_CTRL 8'h7F
`define MPC_MASK_AXIS_STANDBY_CTRL 8'h3F

// motion_detect_ctrl fields
`define MPC_BIT_MOTION_DETECT_ON 7
`define MPC_BIT_MOTION_COMPARE_MODE 6
`define MPC_BIT_OUTPUT_CLAMP 1
`define MPC_BIT_THRESHOLD_COMBINE 0

// fifo_and_path_ctrl fields
`define MPC_BIT_FIFO_ACCESS 6
`define MPC_BIT_FIFO_FLUSH 2
`define MPC_BIT_SENSOR_PATH_CLEAR 0

// power_clock_ctrl fields
`define MPC_BIT_DEVICE_RESET 7
`define MPC_BIT_SLEEP 6
`define MPC_BIT_CYCLE 5
`define MPC_BIT_GYRO_STANDBY 4
`define MPC_BIT_THERMAL_SENSOR_OFF 3
`define MPC_CLK_PICK_MSB 2
`define MPC_CLK_PICK_LSB 0

// axis_standby_ctrl fields: accel x,y,z at 5..3, gyro x,y,z at 2..0
`define MPC_ACCEL_OFF_LSB 3
`define MPC_RATE_OFF_LSB 0

// duty-cycle base period: one divider step in microseconds
`define MPC_CYCLE_BASE_US 1000
`define MPC_CLK_MHZ 50
`define MPC_CYCLE_BASE_CYCLES (`MPC_CYCLE_BASE_US * `MPC_CLK_MHZ)

`endif

// ---- src/motion_power_control_pkg.sv ----
// types for the motion / power control register bank
// assumes motion_power_control_params.svh for all numeric constants
package motion_power_control_pkg;

  typedef enum logic [2:0]
  {
    PS_ACTIVE,
    PS_SLEEP,
    PS_DOZE,
    PS_SAMPLE,
    PS_STOPPED
  } power_state_t;

  typedef enum logic [1:0]
  {
    CS_OSC,
    CS_PLL,
    CS_STOPPED
  } clock_source_t;

endpackage : motion_power_control_pkg

// ---- src/motion_power_control_regs.sv ----
// motion / power control register bank: four byte registers and the control they steer
// assumes a single-cycle strobe bus on sys_clk_in and same-clock sensor logic around it;
// only pll_ready_in comes from another domain
`include "motion_power_control_params.svh"
`timescale 1ns/100ps
`default_nettype none

module motion_power_control_regs
  import motion_power_control_pkg::*;
#(
  parameter int unsigned CYCLE_BASE_CYCLES = `MPC_CYCLE_BASE_CYCLES
)
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [7:0] sample_rate_divider_in,
  input wire logic accel_sample_valid_in,
  input wire logic [2:0] accel_over_in,
  input wire logic pll_ready_in,
  output logic wake_on_motion_active_out,
  output logic motion_compare_mode_out,
  output logic output_clamp_off_out,
  output logic wake_on_motion_out,
  output logic fifo_enable_out,
  output logic fifo_flush_out,
  output logic sensor_path_clear_out,
  output logic sleep_out,
  output logic cycle_wake_out,
  output logic accel_sample_out,
  output logic gyro_drive_on_out,
  output logic pll_on_out,
  output logic [2:0] gyro_sense_on_out,
  output logic [2:0] accel_axis_on_out,
  output logic thermal_sensor_on_out,
  output logic clock_use_pll_out,
  output logic clock_stopped_out,
  output logic timing_reset_out
);

  localparam logic [31:0] BASE_LAST = 32'(CYCLE_BASE_CYCLES - 1);

  // register state
  logic [7:0] motion_detect_ctrl_reg;
  logic [7:0] motion_detect_ctrl_next;
  logic [7:0] fifo_and_path_ctrl_reg;
  logic [7:0] fifo_and_path_ctrl_next;
  logic [7:0] power_clock_ctrl_reg;
  logic [7:0] power_clock_ctrl_next;
  logic [7:0] axis_standby_ctrl_reg;
  logic [7:0] axis_standby_ctrl_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // pll ready synchroniser
  logic pll_meta_reg;
  logic pll_sync_reg;

  // duty-cycle sequencer
  power_state_t state_reg;
  power_state_t state_next;
  logic [31:0] base_cnt_reg;
  logic [31:0] base_cnt_next;
  logic [7:0] step_cnt_reg;
  logic [7:0] step_cnt_next;
  logic cycle_wake_reg;
  logic cycle_wake_next;
  logic accel_sample_reg;
  logic accel_sample_next;

  // motion detection
  logic wom_reg;
  logic wom_next;

  logic wr_motion;
  logic wr_fifo;
  logic wr_power;
  logic wr_standby;
  logic [2:0] accel_on;
  logic [2:0] rate_on;
  logic any_accel_on;
  logic cycling;
  logic [2:0] clk_pick;
  clock_source_t clock_source;

  assign wr_motion = reg_wr_in && (reg_addr_in == `MPC_OFS_MOTION_DETECT_CTRL);
  assign wr_fifo = reg_wr_in && (reg_addr_in == `MPC_OFS_FIFO_AND_PATH_CTRL);
  assign wr_power = reg_wr_in && (reg_addr_in == `MPC_OFS_POWER_CLOCK_CTRL);
  assign wr_standby = reg_wr_in && (reg_addr_in == `MPC_OFS_AXIS_STANDBY_CTRL);

  // ---------------------------------------------------------------- registers
  always_comb
  begin
    motion_detect_ctrl_next = motion_detect_ctrl_reg;
    fifo_and_path_ctrl_next = fifo_and_path_ctrl_reg;
    power_clock_ctrl_next = power_clock_ctrl_reg;
    axis_standby_ctrl_next = axis_standby_ctrl_reg;
    // flush and path clear are one-cycle strobes held in the register
    fifo_and_path_ctrl_next[`MPC_BIT_FIFO_FLUSH] = 1'b0;
    fifo_and_path_ctrl_next[`MPC_BIT_SENSOR_PATH_CLEAR] = 1'b0;
    if (power_clock_ctrl_reg[`MPC_BIT_DEVICE_RESET])
    begin
      // a pending device reset beats any write in the same cycle
      motion_detect_ctrl_next = `MPC_RST_MOTION_DETECT_CTRL;
      fifo_and_path_ctrl_next = `MPC_RST_FIFO_AND_PATH_CTRL;
      power_clock_ctrl_next = `MPC_RST_POWER_CLOCK_CTRL;
      axis_standby_ctrl_next = `MPC_RST_AXIS_STANDBY_CTRL;
    end
    else if (wr_motion)
      motion_detect_ctrl_next = reg_wdata_in & `MPC_MASK_MOTION_DETECT_CTRL;
    else if (wr_fifo)
      fifo_and_path_ctrl_next = reg_wdata_in & `MPC_MASK_FIFO_AND_PATH_CTRL;
    else if (wr_power)
    begin
      power_clock_ctrl_next = reg_wdata_in & `MPC_MASK_POWER_CLOCK_CTRL;
      power_clock_ctrl_next[`MPC_BIT_DEVICE_RESET] = reg_wdata_in[`MPC_BIT_DEVICE_RESET];
    end
    else if (wr_standby)
      axis_standby_ctrl_next = reg_wdata_in & `MPC_MASK_AXIS_STANDBY_CTRL;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      motion_detect_ctrl_reg <= `MPC_RST_MOTION_DETECT_CTRL;
      fifo_and_path_ctrl_reg <= `MPC_RST_FIFO_AND_PATH_CTRL;
      power_clock_ctrl_reg <= `MPC_RST_POWER_CLOCK_CTRL;
      axis_standby_ctrl_reg <= `MPC_RST_AXIS_STANDBY_CTRL;
    end
    else
    begin
      motion_detect_ctrl_reg <= motion_detect_ctrl_next;
      fifo_and_path_ctrl_reg <= fifo_and_path_ctrl_next;
      power_clock_ctrl_reg <= power_clock_ctrl_next;
      axis_standby_ctrl_reg <= axis_standby_ctrl_next;
    end
  end

  // ---------------------------------------------------------------- read port
  always_comb
  begin
    rdata_next = 8'h00;
    // reset bit of the power register shows one only while the reset is still pending
    if (reg_rd_in && (reg_addr_in == `MPC_OFS_MOTION_DETECT_CTRL))
      rdata_next = motion_detect_ctrl_reg;
    else if (reg_rd_in && (reg_addr_in == `MPC_OFS_FIFO_AND_PATH_CTRL))
      rdata_next = fifo_and_path_ctrl_reg;
    else if (reg_rd_in && (reg_addr_in == `MPC_OFS_POWER_CLOCK_CTRL))
      rdata_next = power_clock_ctrl_reg;
    else if (reg_rd_in && (reg_addr_in == `MPC_OFS_AXIS_STANDBY_CTRL))
      rdata_next = axis_standby_ctrl_reg;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end

  assign reg_rdata_out = rdata_reg;

  // ---------------------------------------------------------------- pll ready sync
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      pll_meta_reg <= 1'b0;
      pll_sync_reg <= 1'b0;
    end
    else
    begin
      pll_meta_reg <= pll_ready_in;
      pll_sync_reg <= pll_meta_reg;
    end
  end

  // ---------------------------------------------------------------- per-axis enables
  genvar axis;
  generate
    for (axis = 0; axis < 3; axis++)
    begin : g_axis
      // bit order: x at the highest position of each triple
      assign accel_on[axis] = ~axis_standby_ctrl_reg[`MPC_ACCEL_OFF_LSB + 2 - axis];
      assign rate_on[axis] = ~axis_standby_ctrl_reg[`MPC_RATE_OFF_LSB + 2 - axis];
    end
  endgenerate

  assign any_accel_on = |accel_on;

  // ---------------------------------------------------------------- clock source
  assign clk_pick = power_clock_ctrl_reg[`MPC_CLK_PICK_MSB:`MPC_CLK_PICK_LSB];

  always_comb
  begin
    case (clk_pick)
      3'h0, 3'h6: clock_source = CS_OSC;
      3'h7: clock_source = CS_STOPPED;
      default: clock_source = pll_sync_reg ? CS_PLL : CS_OSC;
    endcase
  end

  assign clock_use_pll_out = (clock_source == CS_PLL);
  assign clock_stopped_out = (clock_source == CS_STOPPED);
  assign timing_reset_out = (clock_source == CS_STOPPED);

  // ---------------------------------------------------------------- duty-cycle sequencer
  assign cycling = power_clock_ctrl_reg[`MPC_BIT_CYCLE]
                   && !power_clock_ctrl_reg[`MPC_BIT_SLEEP]
                   && !power_clock_ctrl_reg[`MPC_BIT_GYRO_STANDBY];

  always_comb
  begin
    state_next = state_reg;
    base_cnt_next = base_cnt_reg;
    step_cnt_next = step_cnt_reg;
    cycle_wake_next = 1'b0;
    accel_sample_next = 1'b0;
    case (state_reg)
      PS_ACTIVE:
      begin
        base_cnt_next = 32'h0;
        step_cnt_next = 8'h00;
        if (clock_source == CS_STOPPED)
          state_next = PS_STOPPED;
        else if (power_clock_ctrl_reg[`MPC_BIT_SLEEP])
          state_next = PS_SLEEP;
        else if (cycling)
          state_next = PS_DOZE;
      end
      PS_SLEEP:
      begin
        if (!power_clock_ctrl_reg[`MPC_BIT_SLEEP])
          state_next = PS_ACTIVE;
      end
      PS_DOZE:
      begin
        // wake period is (divider + 1) base periods in doze plus one cycle in the sample state
        if (!cycling || (clock_source == CS_STOPPED))
          state_next = PS_ACTIVE;
        else if (base_cnt_reg >= BASE_LAST)
        begin
          base_cnt_next = 32'h0;
          if (step_cnt_reg >= sample_rate_divider_in)
          begin
            step_cnt_next = 8'h00;
            state_next = PS_SAMPLE;
          end
          else
          begin
            step_cnt_next = step_cnt_reg + 8'h01;
          end
        end
        else
        begin
          base_cnt_next = base_cnt_reg + 32'h1;
        end
      end
      PS_SAMPLE:
      begin
        cycle_wake_next = 1'b1;
        accel_sample_next = any_accel_on;
        state_next = PS_DOZE;
      end
      PS_STOPPED:
      begin
        if (clock_source != CS_STOPPED)
          state_next = PS_ACTIVE;
      end
      default:
      begin
        state_next = PS_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      state_reg <= PS_ACTIVE;
      base_cnt_reg <= 32'h0;
      step_cnt_reg <= 8'h00;
      cycle_wake_reg <= 1'b0;
      accel_sample_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      base_cnt_reg <= base_cnt_next;
      step_cnt_reg <= step_cnt_next;
      cycle_wake_reg <= cycle_wake_next;
      accel_sample_reg <= accel_sample_next;
    end
  end

  // ---------------------------------------------------------------- wake on motion
  always_comb
  begin
    wom_next = 1'b0;
    // only axes that are switched on take part; both vectors carry x in bit 2, z in bit 0
    if (motion_detect_ctrl_reg[`MPC_BIT_MOTION_DETECT_ON] && accel_sample_valid_in && any_accel_on)
    begin
      if (motion_detect_ctrl_reg[`MPC_BIT_THRESHOLD_COMBINE])
        wom_next = &(accel_over_in | ~accel_axis_on_out);
      else
        wom_next = |(accel_over_in & accel_axis_on_out);
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      wom_reg <= 1'b0;
    else
      wom_reg <= wom_next;
  end

  // ---------------------------------------------------------------- outputs
  assign wake_on_motion_active_out = motion_detect_ctrl_reg[`MPC_BIT_MOTION_DETECT_ON];
  assign motion_compare_mode_out = motion_detect_ctrl_reg[`MPC_BIT_MOTION_COMPARE_MODE];
  assign output_clamp_off_out = motion_detect_ctrl_reg[`MPC_BIT_OUTPUT_CLAMP];
  assign wake_on_motion_out = wom_reg;
  assign fifo_enable_out = fifo_and_path_ctrl_reg[`MPC_BIT_FIFO_ACCESS];
  assign fifo_flush_out = fifo_and_path_ctrl_reg[`MPC_BIT_FIFO_FLUSH];
  assign sensor_path_clear_out = fifo_and_path_ctrl_reg[`MPC_BIT_SENSOR_PATH_CLEAR];
  assign sleep_out = (state_reg == PS_SLEEP) || (state_reg == PS_DOZE);
  assign cycle_wake_out = cycle_wake_reg;
  assign accel_sample_out = accel_sample_reg;
  // gyro drive and pll stay up in gyro standby so the gyros restart quickly
  assign gyro_drive_on_out = (state_reg == PS_ACTIVE);
  assign pll_on_out = (state_reg == PS_ACTIVE);
  assign gyro_sense_on_out = (gyro_drive_on_out && !power_clock_ctrl_reg[`MPC_BIT_GYRO_STANDBY])
                             ? {rate_on[0], rate_on[1], rate_on[2]} : 3'h0;
  assign accel_axis_on_out = {accel_on[0], accel_on[1], accel_on[2]};
  assign thermal_sensor_on_out = !power_clock_ctrl_reg[`MPC_BIT_THERMAL_SENSOR_OFF]
                                 && (state_reg == PS_ACTIVE);

endmodule : motion_power_control_regs

`default_nettype wire

// ---- sim/motion_power_control_regs_asserts.sv ----
// port checker for the motion / power control register bank
// assumes it is bound onto motion_power_control_regs, single clock domain
`timescale 1ns/100ps
`default_nettype none
module motion_power_control_regs_asserts
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic accel_sample_valid_in,
  input wire logic wake_on_motion_active_out,
  input wire logic wake_on_motion_out,
  input wire logic fifo_enable_out,
  input wire logic fifo_flush_out,
  input wire logic sensor_path_clear_out,
  input wire logic sleep_out,
  input wire logic cycle_wake_out,
  input wire logic accel_sample_out,
  input wire logic [2:0] gyro_sense_on_out,
  input wire logic [2:0] accel_axis_on_out,
  input wire logic thermal_sensor_on_out,
  input wire logic clock_use_pll_out,
  input wire logic clock_stopped_out,
  input wire logic timing_reset_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  logic w6a;
  logic w6b;
  // device reset writes are left out: they restore defaults instead
  assign w6a = reg_wr_in && reg_addr_in == 8'h6A;
  assign w6b = reg_wr_in && reg_addr_in == 8'h6B && !reg_wdata_in[7];
  a_flush_self_clear: assert property (w6a && reg_wdata_in[2] |=> fifo_flush_out ##1 !fifo_flush_out)
    else $error("flush bit did not pulse for one cycle");
  a_path_clear_pulse: assert property (w6a && reg_wdata_in[0] |=> sensor_path_clear_out ##1 !sensor_path_clear_out)
    else $error("path clear did not pulse for one cycle");
  a_accel_axis_map: assert property (reg_wr_in && reg_addr_in == 8'h6C |=> accel_axis_on_out == ~$past(reg_wdata_in[5:3]))
    else $error("accel axis enables do not follow standby bits");
  a_gyro_sense_off: assert property (w6b && reg_wdata_in[4] |=> gyro_sense_on_out == 3'h0)
    else $error("gyro sense on during gyro standby");
  a_thermal_kept_off: assert property (w6b && reg_wdata_in[3] |=> !thermal_sensor_on_out)
    else $error("thermal sensor on while disabled");
  a_clock_stop_code: assert property (w6b && reg_wdata_in[2:0] == 3'h7 |=> clock_stopped_out && timing_reset_out && !clock_use_pll_out)
    else $error("clock code 7 did not stop clock");
  a_osc_code_used: assert property (w6b && (reg_wdata_in[2:0] == 3'h0 || reg_wdata_in[2:0] == 3'h6) |=> !clock_use_pll_out && !clock_stopped_out)
    else $error("oscillator code did not select oscillator");
  a_sleep_held: assert property (w6b && reg_wdata_in[6] |-> ##2 sleep_out [*3])
    else $error("sleep bit did not hold sleep");
  a_defaults_back: assert property (reg_wr_in && reg_addr_in == 8'h6B && reg_wdata_in[7] |-> ##2 (!fifo_enable_out && accel_axis_on_out == 3'h7 && !wake_on_motion_active_out && !clock_stopped_out))
    else $error("device reset did not restore defaults");
  a_wake_cause: assert property (wake_on_motion_out |-> $past(accel_sample_valid_in) && $past(wake_on_motion_active_out))
    else $error("wake on motion without enabled sample");
  a_no_axis_sample: assert property (accel_sample_out |-> cycle_wake_out && $past(accel_axis_on_out) != 3'h0)
    else $error("sample taken with all accel axes off");
  a_reserved_zero: assert property (reg_rd_in && reg_addr_in == 8'h6A |=> (reg_rdata_out & 8'hBA) == 8'h00)
    else $error("reserved bits read nonzero");
  c_flush: cover property (w6a && reg_wdata_in[2]);
  c_wake: cover property (wake_on_motion_out);
  c_sample: cover property (accel_sample_out);
  c_empty_wake: cover property (cycle_wake_out && !accel_sample_out);
endmodule : motion_power_control_regs_asserts
bind motion_power_control_regs motion_power_control_regs_asserts i_chk (.sys_clk_in, .reset_n_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .accel_sample_valid_in, .wake_on_motion_active_out,
  .wake_on_motion_out, .fifo_enable_out, .fifo_flush_out, .sensor_path_clear_out, .sleep_out, .cycle_wake_out,
  .accel_sample_out, .gyro_sense_on_out, .accel_axis_on_out, .thermal_sensor_on_out, .clock_use_pll_out,
  .clock_stopped_out, .timing_reset_out);
`default_nettype wire

// ---- sim/host_bus_model.sv ----
// host model driving the register strobe port, one request at a time
// assumes the bank takes strobes on the rising edge and answers reads next cycle
`timescale 1ns/100ps
`default_nettype none
module host_bus_model
(
  input wire logic sys_clk_in,
  input wire logic [7:0] rdata_in,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  initial
  begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // released lines show the inverse of the last value so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    wr_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
    @(posedge sys_clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    rd_out <= 1'b1;
    addr_out <= a;
    @(posedge sys_clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    @(negedge sys_clk_in);
    d = rdata_in;
  endtask : rd
  // setup the host owes after every power-up
  task automatic start_up();
    wr(8'h6B, 8'h01);
    wr(8'h69, 8'h42);
  endtask : start_up
endmodule : host_bus_model
`default_nettype wire

// ---- sim/motion_power_control_regs_tb_top.sv ----
// self-checking bench for the motion / power control register bank
// assumes host_bus_model and the bound checker are compiled beforehand
`timescale 1ns/100ps
`default_nettype none
module motion_power_control_regs_tb_top;
  logic sys_clk_in;
  logic reset_n_in;
  logic [7:0] div;
  logic valid;
  logic [2:0] over;
  logic pll_rdy;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd, wom_act, cmp_mode, clamp_off, wake_on_motion, fifo_en, flush, path_clr, sleep, wake, sample;
  logic drive, pll_on, therm, use_pll, stopped, treset;
  logic [2:0] sense, axis;
  int miscompares, tests_run, cyc, n;
  host_bus_model i_host (.sys_clk_in(sys_clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd));
  // short base step keeps duty-cycle waits to a few cycles
  motion_power_control_regs #(.CYCLE_BASE_CYCLES(4)) i_dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .sample_rate_divider_in(div), .accel_sample_valid_in(valid), .accel_over_in(over), .pll_ready_in(pll_rdy),
    .wake_on_motion_active_out(wom_act), .motion_compare_mode_out(cmp_mode), .output_clamp_off_out(clamp_off),
    .wake_on_motion_out(wake_on_motion), .fifo_enable_out(fifo_en), .fifo_flush_out(flush),
    .sensor_path_clear_out(path_clr), .sleep_out(sleep), .cycle_wake_out(wake), .accel_sample_out(sample),
    .gyro_drive_on_out(drive), .pll_on_out(pll_on), .gyro_sense_on_out(sense), .accel_axis_on_out(axis),
    .thermal_sensor_on_out(therm), .clock_use_pll_out(use_pll), .clock_stopped_out(stopped),
    .timing_reset_out(treset));
  initial
  begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  always @(posedge sys_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      miscompares++;
      close_out();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, d);
    check(d, e);
  endtask : rchk
  task automatic settle();
    repeat (2) @(negedge sys_clk_in);
  endtask : settle
  task automatic pulse(input logic [2:0] o, input logic e);
    @(posedge sys_clk_in);
    valid <= 1'b1;
    over <= o;
    @(posedge sys_clk_in);
    valid <= 1'b0;
    @(negedge sys_clk_in);
    check(wake_on_motion, e);
  endtask : pulse
  task automatic wait_wake();
    n = 0;
    do
    begin
      @(negedge sys_clk_in);
      n++;
    end
    while (wake !== 1'b1 && n < 100);
    check(wake, 1);
  endtask : wait_wake
  task automatic t_reset_values();
    rchk(8'h6B, 8'h01);
    rchk(8'h69, 8'h00);
    rchk(8'h6A, 8'h00);
    rchk(8'h6C, 8'h00);
    rchk(8'h70, 8'h00);
    check(axis, 3'h7);
    check(sense, 3'h7);
    check(therm, 1);
  endtask : t_reset_values
  task automatic t_motion();
    i_host.wr(8'h69, 8'hFF);
    rchk(8'h69, 8'hC3);
    check(wom_act, 1);
    check(cmp_mode, 1);
    check(clamp_off, 1);
    pulse(3'b110, 0);
    pulse(3'b111, 1);
    i_host.wr(8'h6C, 8'h20);
    pulse(3'b011, 1);
    i_host.wr(8'h6C, 8'h00);
    i_host.wr(8'h69, 8'hC2);
    pulse(3'b100, 1);
    pulse(3'b000, 0);
    i_host.wr(8'h69, 8'h42);
    pulse(3'b111, 0);
  endtask : t_motion
  task automatic t_fifo_bits();
    i_host.wr(8'h6A, 8'hFF);
    @(negedge sys_clk_in);
    check(flush, 1);
    check(path_clr, 1);
    check(fifo_en, 1);
    @(negedge sys_clk_in);
    check(flush, 0);
    check(path_clr, 0);
    rchk(8'h6A, 8'h40);
    i_host.wr(8'h6A, 8'h00);
    @(negedge sys_clk_in);
    check(fifo_en, 0);
  endtask : t_fifo_bits
  task automatic t_power_bits();
    i_host.wr(8'h6B, 8'h41);
    settle();
    check(sleep, 1);
    i_host.wr(8'h6B, 8'h19);
    settle();
    check(sleep, 0);
    check(sense, 3'h0);
    check({drive, pll_on}, 2'b11);
    check(therm, 0);
    for (int i = 0; i < 8; i++)
    begin
      i_host.wr(8'h6B, 8'(i));
      settle();
      check(use_pll, i >= 1 && i <= 5);
      check({stopped, treset}, {2{i == 7}});
    end
    @(posedge sys_clk_in);
    pll_rdy <= 1'b0;
    i_host.wr(8'h6B, 8'h01);
    settle();
    check(use_pll, 0);
    @(posedge sys_clk_in);
    pll_rdy <= 1'b1;
  endtask : t_power_bits
  task automatic t_standby_bits();
    logic [7:0] pat [2];
    pat = '{8'h2A, 8'h15};
    for (int i = 0; i < 2; i++)
    begin
      i_host.wr(8'h6C, pat[i]);
      settle();
      check(axis, {5'h00, ~pat[i][5:3]});
      check(sense, {5'h00, ~pat[i][2:0]});
    end
    i_host.wr(8'h6C, 8'hFF);
    rchk(8'h6C, 8'h3F);
    i_host.wr(8'h6C, 8'h00);
  endtask : t_standby_bits
  task automatic t_duty_cycle();
    div <= 8'h01;
    i_host.wr(8'h6B, 8'h21);
    wait_wake();
    check(sample, 1);
    check({sleep, drive}, 2'b10);
    wait_wake();
    check(8'(n), 8'h09);
    i_host.wr(8'h6C, 8'h38);
    wait_wake();
    wait_wake();
    check(sample, 0);
    i_host.wr(8'h6B, 8'h01);
    i_host.wr(8'h6C, 8'h00);
  endtask : t_duty_cycle
  task automatic t_device_reset();
    i_host.wr(8'h69, 8'h43);
    i_host.wr(8'h6A, 8'h40);
    i_host.wr(8'h6C, 8'h3F);
    i_host.wr(8'h6B, 8'h80);
    rchk(8'h6B, 8'h01);
    rchk(8'h69, 8'h00);
    rchk(8'h6A, 8'h00);
    rchk(8'h6C, 8'h00);
    check(axis, 3'h7);
    i_host.start_up();
  endtask : t_device_reset
  initial
  begin
    reset_n_in = 1'b0;
    div = 8'h00;
    valid = 1'b0;
    over = 3'h0;
    pll_rdy = 1'b1;
    miscompares = 0;
    tests_run = 0;
    cyc = 0;
    repeat (2) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    t_reset_values();
    i_host.start_up();
    t_motion();
    t_fifo_bits();
    t_power_bits();
    t_standby_bits();
    t_duty_cycle();
    t_device_reset();
    close_out();
  end
endmodule : motion_power_control_regs_tb_top
`default_nettype wire
